// ==== include/ncel_params.svh ====
// constants for the node config error list command block
`ifndef NCEL_PARAMS_SVH
`define NCEL_PARAMS_SVH
`define NCEL_OP_DELTA 8'h57
`define NCEL_OP_HIST 8'h60
`define NCEL_RSP_LEN 4'ha
`define NCEL_REQ_LEN 2'h2
`define NCEL_ERR_OK 7'h00
`define NCEL_ERR_BADREQ 7'h01
`define NCEL_TOGGLE_BIT 7
`define NCEL_ZERO_BIT 6
`define NCEL_SEG_BIT 0
`define NCEL_NODES 64
`endif

// ==== include/ncel_pkg.sv ====
// types for the node config error list command block
package ncel_pkg;
  typedef enum logic [1:0] {
    NCEL_IDLE = 2'b00,
    NCEL_HDR = 2'b01,
    NCEL_SEND = 2'b10
  } ncel_state_e;
  typedef logic [63:0] ncel_map_t;
endpackage : ncel_pkg

// ==== logic/ncel_cmd.sv ====
// command interpreter for delta and history node list commands
// Function
// (R1) delta bit is 1 where expected and detected configurations differ, else 0
// (R2) bit positions without a node address are forced to zero
// (R3) keep sticky history of nodes with configuration errors since reset or read
// (R4) history request has header only; no payload bytes accepted
// (R5) history response payload is exactly eight bytes after header
// (R6) host sends 0x60, toggle bit 7, zero bit 6, segment bit 0
// (R7) answer 0x60, toggle and error code, then A map then B map
// (R8) history bit 1 when enabled node became disabled, else 0
// (R9) history bit stays set until host reads history list
// (R10) toggle bit of request echoed in response byte 1 bit 7
`timescale 1ns/1ps
`include "ncel_params.svh"
module ncel_cmd
  import ncel_pkg::*;
#(
  parameter int NODES = `NCEL_NODES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] req_byte,
  input wire logic req_valid,
  input wire logic req_last,
  input wire logic [NODES-1:0] cfg_expected_seg0,
  input wire logic [NODES-1:0] cfg_detected_seg0,
  input wire logic [NODES-1:0] cfg_expected_seg1,
  input wire logic [NODES-1:0] cfg_detected_seg1,
  input wire logic [NODES-1:0] node_active_seg0,
  input wire logic [NODES-1:0] node_active_seg1,
  output logic [7:0] rsp_byte,
  output logic rsp_valid,
  output logic rsp_last
);
  logic [NODES-1:0] act0_reg, act0_next, act1_reg, act1_next;
  logic [NODES-1:0] lost0, lost1, hist0, hist1, valid_mask;
  logic hist_ok, delta_ok, hist_read, clr0, clr1;
  logic [6:0] err_code;
  ncel_state_e state_reg, state_next;
  logic [1:0] cnt_reg, cnt_next;
  logic [7:0] op_reg, op_next;
  logic [7:0] b1_reg, b1_next;
  logic hdr_ok_reg, hdr_ok_next;
  logic [3:0] idx_reg, idx_next;
  ncel_map_t map_reg, map_next;
  logic [7:0] map_byte [8];
  logic [7:0] rsp_byte_reg, rsp_byte_next;
  logic rsp_valid_reg, rsp_valid_next, rsp_last_reg, rsp_last_next;

  // (R2) address zero carries no node
  assign valid_mask = {{(NODES/2-1){1'b1}}, 1'b0, {(NODES/2-1){1'b1}}, 1'b0};
  // (R8) enabled node that went disabled
  assign lost0 = act0_reg & ~node_active_seg0 & valid_mask;
  assign lost1 = act1_reg & ~node_active_seg1 & valid_mask;

  // request verdict, settled once the header is in
  assign hist_ok = (op_reg == `NCEL_OP_HIST) && hdr_ok_reg && !b1_reg[`NCEL_ZERO_BIT];
  assign delta_ok = (op_reg == `NCEL_OP_DELTA) && hdr_ok_reg;
  assign err_code = (hist_ok || delta_ok) ? `NCEL_ERR_OK : `NCEL_ERR_BADREQ;
  // (R9) read clears on the snapshot edge, a loss there survives
  assign hist_read = (state_reg == NCEL_SEND) && (idx_reg == 4'h0) && hist_ok;
  assign clr0 = hist_read & ~b1_reg[`NCEL_SEG_BIT];
  assign clr1 = hist_read & b1_reg[`NCEL_SEG_BIT];

  ncel_history #(.NODES(NODES)) u_hist (
    .clk(clk),
    .nrst(nrst),
    .node_lost_seg0(lost0),
    .node_lost_seg1(lost1),
    .clear_seg0(clr0),
    .clear_seg1(clr1),
    .hist_seg0(hist0),
    .hist_seg1(hist1)
  );

  // map bytes, lowest node numbers first
  genvar j;
  generate
    for (j = 0; j < 8; j++) begin : g_byte
      assign map_byte[j] = map_reg[8*j +: 8];
    end
  endgenerate

  // node activity of the previous cycle
  always_comb begin
    act0_next = node_active_seg0;
    act1_next = node_active_seg1;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      act0_reg <= '0;
      act1_reg <= '0;
    end else begin
      act0_reg <= act0_next;
      act1_reg <= act1_next;
    end
  end

  // request capture and frame sequencing
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    op_next = op_reg;
    b1_next = b1_reg;
    hdr_ok_next = hdr_ok_reg;
    case (state_reg)
      NCEL_IDLE: begin
        if (req_valid) begin
          op_next = req_byte;
          cnt_next = 2'h1;
          hdr_ok_next = ~req_last;
          state_next = req_last ? NCEL_SEND : NCEL_HDR;
        end
      end
      NCEL_HDR: begin
        if (req_valid) begin
          if (cnt_reg == `NCEL_REQ_LEN - 2'h1) begin
            b1_next = req_byte;
          end
          if (cnt_reg != 2'h3) begin
            cnt_next = cnt_reg + 2'h1;
          end
          if (req_last) begin
            // (R4) header only, no payload
            hdr_ok_next = hdr_ok_reg & (cnt_reg == `NCEL_REQ_LEN - 2'h1);
            state_next = NCEL_SEND;
          end
        end
      end
      NCEL_SEND: begin
        // (R5) back to idle after the tenth byte
        if (idx_reg == `NCEL_RSP_LEN - 4'h1) begin
          state_next = NCEL_IDLE;
        end
      end
      default: begin
        state_next = NCEL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= NCEL_IDLE;
      cnt_reg <= 2'h0;
      op_reg <= 8'h00;
      b1_reg <= 8'h00;
      hdr_ok_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      op_reg <= op_next;
      b1_reg <= b1_next;
      hdr_ok_reg <= hdr_ok_next;
    end
  end

  // response stream: opcode, status, then map
  always_comb begin
    idx_next = 4'h0;
    map_next = map_reg;
    rsp_byte_next = 8'h00;
    rsp_valid_next = 1'b0;
    rsp_last_next = 1'b0;
    if (state_reg == NCEL_SEND) begin
      rsp_valid_next = 1'b1;
      idx_next = idx_reg + 4'h1;
      if (idx_reg == 4'h0) begin
        rsp_byte_next = op_reg;
        if (hist_ok) begin
          // (R3) snapshot of the selected history segment
          map_next = b1_reg[`NCEL_SEG_BIT] ? hist1 : hist0;
        end else if (delta_ok) begin
          // (R1) mismatch flags
          map_next = b1_reg[`NCEL_SEG_BIT] ? (cfg_expected_seg1 ^ cfg_detected_seg1)
                                           : (cfg_expected_seg0 ^ cfg_detected_seg0);
        end else begin
          map_next = '0;
        end
        // (R2) undefined positions zero
        map_next = map_next & valid_mask;
      end else if (idx_reg == 4'h1) begin
        // (R10) echo toggle bit
        rsp_byte_next = {b1_reg[`NCEL_TOGGLE_BIT], err_code};
      end else begin
        // (R7) byte 2 holds nodes 7..0 of A, byte 6 starts B
        rsp_byte_next = map_byte[idx_reg[2:0] - 3'h2];
      end
      // (R5) eight payload bytes then end
      if (idx_reg == `NCEL_RSP_LEN - 4'h1) begin
        rsp_last_next = 1'b1;
        idx_next = 4'h0;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      idx_reg <= 4'h0;
      map_reg <= '0;
      rsp_byte_reg <= 8'h00;
      rsp_valid_reg <= 1'b0;
      rsp_last_reg <= 1'b0;
    end else begin
      idx_reg <= idx_next;
      map_reg <= map_next;
      rsp_byte_reg <= rsp_byte_next;
      rsp_valid_reg <= rsp_valid_next;
      rsp_last_reg <= rsp_last_next;
    end
  end

  assign rsp_byte = rsp_byte_reg;
  assign rsp_valid = rsp_valid_reg;
  assign rsp_last = rsp_last_reg;
endmodule : ncel_cmd

// ==== logic/ncel_history.sv ====
// sticky configuration error history bits, two segments
`timescale 1ns/1ps
`include "ncel_params.svh"
module ncel_history
  import ncel_pkg::*;
#(
  parameter int NODES = `NCEL_NODES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [NODES-1:0] node_lost_seg0,
  input wire logic [NODES-1:0] node_lost_seg1,
  input wire logic clear_seg0,
  input wire logic clear_seg1,
  output logic [NODES-1:0] hist_seg0,
  output logic [NODES-1:0] hist_seg1
);
  logic [NODES-1:0] h0_reg, h0_next, h1_reg, h1_next;
  genvar i;
  generate
    for (i = 0; i < NODES; i++) begin : g_bit
      always_comb begin
        // (R9) sticky, set beats clear
        h0_next[i] = node_lost_seg0[i] | (h0_reg[i] & ~clear_seg0);
        h1_next[i] = node_lost_seg1[i] | (h1_reg[i] & ~clear_seg1);
      end
    end
  endgenerate
  // (R3) history kept since reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      h0_reg <= '0;
      h1_reg <= '0;
    end else begin
      h0_reg <= h0_next;
      h1_reg <= h1_next;
    end
  end
  assign hist_seg0 = h0_reg;
  assign hist_seg1 = h1_reg;
endmodule : ncel_history

// ==== verif/ncel_host.sv ====
// host model sending two byte requests
`timescale 1ns/1ps
module ncel_host (
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] op,
  input wire logic [7:0] ctl,
  output logic [7:0] req_byte,
  output logic req_valid,
  output logic req_last
);
  initial begin
    req_byte = 8'h00;
    req_valid = 1'b0;
    req_last = 1'b0;
    forever begin
      @(posedge clk);
      if (go) begin
        #1 req_byte = op;
        req_valid = 1'b1;
        @(posedge clk);
        #1 req_byte = ctl;
        req_last = 1'b1;
        @(posedge clk);
        #1 req_byte = ~ctl;
        req_valid = 1'b0;
        req_last = 1'b0;
      end
    end
  end
endmodule : ncel_host

// ==== verif/ncel_monitor.sv ====
// port checker for the node list command block
`timescale 1ns/1ps
module ncel_monitor (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] req_byte,
  input wire logic req_valid,
  input wire logic req_last,
  input wire logic [7:0] rsp_byte,
  input wire logic rsp_valid,
  input wire logic rsp_last
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_rsp_ten_long: assert property ($rose(rsp_valid) |-> rsp_valid[*8] ##1 rsp_valid[*2] ##1 !rsp_valid)
    else $error("response length wrong");
  a_answer_two_late: assert property (req_valid && req_last && !rsp_valid |-> ##2 $rose(rsp_valid))
    else $error("answer not on time");
  a_last_at_tenth: assert property (rsp_last |-> rsp_valid && $past(rsp_valid, 9) && !$past(rsp_valid, 10))
    else $error("last flag misplaced");
  a_last_ends_frame: assert property (rsp_last |=> !rsp_valid)
    else $error("frame runs past last");
  a_opcode_echo: assert property ($rose(rsp_valid) |-> rsp_byte == $past(req_byte, 3))
    else $error("opcode not echoed");
  a_toggle_echo: assert property ($rose(rsp_valid) |=> rsp_byte[7] == $past(req_byte[7], 3))
    else $error("toggle not echoed");
  a_no_addr_zero: assert property ($rose(rsp_valid) |-> ##2 !rsp_byte[0] ##4 !rsp_byte[0])
    else $error("address zero bit set");
  a_good_hist_ok: assert property ($rose(rsp_valid) && $past(req_byte, 3) == 8'h60 && !$past(req_byte[6], 2)
    |=> rsp_byte[6:0] == 7'h00)
    else $error("good request flagged");
  a_bad_op_err: assert property ($rose(rsp_valid) && $past(req_byte, 3) != 8'h60 && $past(req_byte, 3) != 8'h57
    |=> rsp_byte[6:0] == 7'h01)
    else $error("unknown opcode not flagged");
  c_request: cover property (req_valid && req_last);
  c_hist_read: cover property ($rose(rsp_valid) && rsp_byte == 8'h60);
  c_response: cover property ($rose(rsp_valid));
  c_frame_end: cover property (rsp_last);
endmodule : ncel_monitor
bind ncel_cmd ncel_monitor u_mon (.clk(clk), .nrst(nrst), .req_byte(req_byte), .req_valid(req_valid),
  .req_last(req_last), .rsp_byte(rsp_byte), .rsp_valid(rsp_valid), .rsp_last(rsp_last));

// ==== verif/tb_top.sv ====
// self-checking bench for the node list command block
`timescale 1ns/1ps
module tb_top import ncel_pkg::*;;
  localparam ncel_map_t MK = 64'hffff_fffe_ffff_fffe;
  logic clk = 0, nrst = 0, go = 0, req_valid, req_last, rsp_valid, rsp_last;
  logic [7:0] op = 0, ctl = 0, c8, req_byte, rsp_byte;
  ncel_map_t ex0 = 0, dt0 = 0, ex1 = 0, dt1 = 0, ac0 = 0, ac1 = 0, m;
  logic [7:0] rb [10];
  logic [1:0] rf [10];
  int miscompares = 0, total_checks = 0, seed = 32'h18de, i;
  always #20 clk = ~clk;
  ncel_host host (.clk(clk), .go(go), .op(op), .ctl(ctl), .req_byte(req_byte), .req_valid(req_valid),
    .req_last(req_last));
  ncel_cmd #(.NODES(64)) dut (.clk(clk), .nrst(nrst), .req_byte(req_byte), .req_valid(req_valid),
    .req_last(req_last), .cfg_expected_seg0(ex0), .cfg_detected_seg0(dt0), .cfg_expected_seg1(ex1),
    .cfg_detected_seg1(dt1), .node_active_seg0(ac0), .node_active_seg1(ac1), .rsp_byte(rsp_byte),
    .rsp_valid(rsp_valid), .rsp_last(rsp_last));
  function automatic ncel_map_t exp_delta(input logic seg, input ncel_map_t e0, d0, e1, d1);
    return (seg ? (e1 ^ d1) : (e0 ^ d0)) & MK;
  endfunction : exp_delta
  function automatic ncel_map_t exp_lost(input ncel_map_t was_on, input ncel_map_t now_on);
    return was_on & ~now_on & MK;
  endfunction : exp_lost
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic run(input logic [7:0] o, input logic [7:0] c, input ncel_map_t em, input logic [6:0] er);
    @(posedge clk);
    #1 op = o;
    ctl = c;
    go = 1;
    @(posedge clk);
    #1 go = 0;
    for (i = 0; i < 20 && rsp_valid !== 1'b1; i++) @(negedge clk);
    for (i = 0; i < 10; i++) begin
      rb[i] = rsp_byte;
      rf[i] = {rsp_valid, rsp_last};
      @(negedge clk);
    end
    for (i = 0; i < 10; i++) chk("frame", {6'h00, 1'b1, i == 9}, {6'h00, rf[i]});
    chk("opcode", o, rb[0]);
    chk("status", {c[7], er}, rb[1]);
    for (i = 2; i < 10; i++) chk("map", em[8*(i-2)+:8], rb[i]);
    $display("test %h %h done", o, c);
  endtask : run
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (10) @(posedge clk);
    #1 nrst = 1;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      #1 {ex0, dt0, ex1, dt1} = {$random(seed), $random(seed), $random(seed), $random(seed),
        $random(seed), $random(seed), $random(seed), $random(seed)};
      c8 = (8'($random(seed)) & 8'h80) | 8'(k % 2);
      run(8'h57, c8, exp_delta(c8[0], ex0, dt0, ex1, dt1), 7'h00);
    end
    @(posedge clk);
    #1 ex0 = '1;
    dt0 = '0;
    run(8'h57, 8'h80, exp_delta(1'b0, ex0, dt0, ex1, dt1), 7'h00);
    @(posedge clk);
    #1 {ex0, m} = {$random(seed), $random(seed), $random(seed), $random(seed)};
    ac0 = ex0;
    ac1 = ~ex0;
    @(posedge clk);
    #1 ac0 = ex0 & ~m;
    ac1 = ~ex0 & ~m;
    @(posedge clk);
    #1 ac0 = ex0;
    ac1 = ~ex0;
    run(8'h60, 8'h80, exp_lost(ex0, ex0 & ~m), 7'h00);
    run(8'h60, 8'h00, 64'h0, 7'h00);
    run(8'h60, 8'h41, 64'h0, 7'h01);
    run(8'h33, 8'h80, 64'h0, 7'h01);
    run(8'h60, 8'h81, exp_lost(~ex0, ~ex0 & ~m), 7'h00);
    give_verdict();
  end
  initial begin
    #100000;
    miscompares++;
    give_verdict();
  end
endmodule : tb_top
